// >>> verilog/bdm_pkg.sv
// Constants, field positions and helper functions for the banked data memory.
// Assumes an 8-bit core on one clock with a synchronous active-low reset.
//
// Function
// (RULE1) Unused special locations read back as 00H.
// (RULE2) Every general-purpose RAM byte is readable and writable.
// (RULE3) Bit set and bit clear change one bit and keep the other seven.
// (RULE4) Protected special registers ignore writes and stay readable.
// (RULE5) Indirect port accesses go to the location held in its pointer.
// (RULE6) Port zero with pointer zero reaches bank 0 only.
// (RULE7) Port one with pointer one reaches either bank.
// (RULE8) Indirect port locations themselves read 00H and ignore writes.
// (RULE9) Both pointers are ordinary read/write registers.
// (RULE10) Data memory has exactly two banks chosen by the bank select.
// (RULE11) Reset clears bank select, except a watchdog reset in idle or sleep.
// (RULE12) Direct addressing always reaches bank 0.
// (RULE13) Software uses port one to reach bank 1 data.
// (RULE14) Bytes are 8 bits; 00H-7FH special, 80H-FFH general purpose.
// (RULE15) Bank 1 80H-FFH is the LED PWM data buffer.
// (RULE16) Bank select holds bit 0 only, resets to 0, bits 7-1 read zero.
// (RULE17) Port one address is the bank select bit joined to pointer one.
package bdm_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned IDX_W  = 7;

    localparam logic [7:0] PORT0_ADDR = 8'h00;
    localparam logic [7:0] PTR0_ADDR  = 8'h01;
    localparam logic [7:0] PORT1_ADDR = 8'h02;
    localparam logic [7:0] PTR1_ADDR  = 8'h03;
    localparam logic [7:0] BANK_ADDR  = 8'h04;
    localparam logic [7:0] PROT_ADDR  = 8'h08;

    localparam int unsigned GP_BIT   = 7;
    localparam int unsigned BANK_BIT = 0;

    localparam logic       BANK0    = 1'b0;
    localparam logic       BANK1    = 1'b1;
    localparam logic       BANK_RST = 1'b0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE  = 8'h01;
    localparam logic [7:0] PTR_RST   = 8'h00;
    localparam logic [6:0] BANK_PAD  = 7'h00;
    localparam logic [6:0] IDX_RST   = 7'h00;

    function automatic logic [7:0] bdm_bit_mask(input logic [2:0] sel);
        bdm_bit_mask = ONE_BYTE << sel;
    endfunction : bdm_bit_mask

    function automatic logic [7:0] bdm_bit_apply(input logic [7:0] old,
                                                 input logic [2:0] sel,
                                                 input logic       set);
        logic [7:0] mask;
        mask = bdm_bit_mask(sel);
        bdm_bit_apply = set ? (old | mask) : (old & ~mask);
    endfunction : bdm_bit_apply

endpackage : bdm_pkg

// >>> verilog/bdm_mem_if.sv
// Carrier between the access logic and the RAM store.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface bdm_mem_if;
    logic       we;
    logic       bank;
    logic [6:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [6:0] pwm_idx;
    logic [7:0] pwm_data;

    modport core  (output we, bank, idx, wdata, pwm_idx, input rdata, pwm_data);
    modport store (input we, bank, idx, wdata, pwm_idx, output rdata, pwm_data);
endinterface : bdm_mem_if

// >>> verilog/bdm_store.sv
// Flip-flop RAM: bank 0 general-purpose bytes and bank 1 LED PWM buffer.
// Assumes the access logic has already resolved bank and index.
`timescale 1ns/1ps
module bdm_store
    import bdm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    bdm_mem_if.store mem
);

    logic [7:0] gp_ram  [0:127];
    logic [7:0] pwm_ram [0:127];

    // Bank 1 upper half is the PWM buffer, bank 0 upper half plain RAM. [RULE15]
    assign mem.rdata = (mem.bank == BANK1) ? pwm_ram[mem.idx] : gp_ram[mem.idx]; // [RULE2]

    // RAM contents carry no reset, which keeps the store small; only the PWM port does.
    always_ff @(posedge clk) begin
        if (mem.we && mem.bank == BANK0) begin
            gp_ram[mem.idx] <= mem.wdata; // [RULE2]
        end
        if (mem.we && mem.bank == BANK1) begin
            pwm_ram[mem.idx] <= mem.wdata; // [RULE15]
        end
    end

    // The PWM engine sees its byte one clock after it presents the index.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem.pwm_data <= ZERO_BYTE;
        end else begin
            mem.pwm_data <= pwm_ram[mem.pwm_idx];
        end
    end

endmodule : bdm_store

// >>> verilog/bdm_top.sv
// Data memory access logic: direct, indirect and bit-level accesses.
// Assumes the CPU core drives one request per clock on clk, and the other
// special registers live outside behind the ext_ read and write ports.
`timescale 1ns/1ps
module bdm_top
    import bdm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       watchdog_timer_idle_rst,
    input  wire logic [7:0] addr,
    input  wire logic       rd_req,
    input  wire logic       wr_req,
    input  wire logic       set_req,
    input  wire logic       clr_req,
    input  wire logic [2:0] bit_sel,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    output logic            rd_valid,
    output logic      [6:0] ext_addr,
    output logic            ext_rd,
    input  wire logic       ext_present,
    input  wire logic [7:0] ext_rdata,
    output logic            ext_wr,
    output logic      [6:0] ext_waddr,
    output logic      [7:0] ext_wdata,
    input  wire logic [6:0] pwm_idx,
    output logic      [7:0] pwm_data,
    output logic            bank_select_bit
);

    bdm_mem_if mem ();

    bdm_store u_store (
        .clk   (clk),
        .rst_n (rst_n),
        .mem   (mem.store)
    );

    logic [7:0] pointer_zero;
    logic [7:0] pointer_one;

    logic       port0_hit;
    logic       port1_hit;
    logic       indirect;
    logic [7:0] tgt_low;
    logic       tgt_bank;
    logic       mem_hit;
    logic       gp_hit;
    logic       spec_hit;
    logic       port_loc;
    logic       ptr0_loc;
    logic       ptr1_loc;
    logic       bank_loc;
    logic       own_loc;
    logic       ext_loc;
    logic       prot_loc;
    logic       upd;
    logic [7:0] cur_val;
    logic [7:0] next_val;
    logic       next_ext_wr;

    // Address resolution. A port address is replaced by its pointer.
    assign port0_hit = (addr == PORT0_ADDR); // [RULE5]
    assign port1_hit = (addr == PORT1_ADDR); // [RULE5]
    assign indirect  = port0_hit | port1_hit;
    assign tgt_low   = port0_hit ? pointer_zero
                     : port1_hit ? pointer_one : addr; // [RULE5]

    // Only port one carries the bank bit; port zero and direct stay in bank 0.
    assign tgt_bank = port1_hit ? bank_select_bit : BANK0; // [RULE6] [RULE7] [RULE12] [RULE17]

    // Upper half of each bank is RAM; lower half is special, bank 0 only.
    assign mem_hit  = tgt_low[GP_BIT]; // [RULE14] [RULE10]
    assign gp_hit   = mem_hit && (tgt_bank == BANK0);
    assign spec_hit = !tgt_low[GP_BIT] && (tgt_bank == BANK0); // [RULE14]

    // A pointer holding a port address lands on a location with no storage.
    assign port_loc = spec_hit && (tgt_low == PORT0_ADDR || tgt_low == PORT1_ADDR); // [RULE8]
    assign ptr0_loc = spec_hit && (tgt_low == PTR0_ADDR);
    assign ptr1_loc = spec_hit && (tgt_low == PTR1_ADDR);
    assign bank_loc = spec_hit && (tgt_low == BANK_ADDR);
    assign own_loc  = port_loc | ptr0_loc | ptr1_loc | bank_loc;
    assign ext_loc  = spec_hit && !own_loc && ext_present;
    assign prot_loc = (tgt_low == PROT_ADDR);

    assign ext_addr = tgt_low[6:0];
    assign ext_rd   = rd_req && ext_loc;

    // Read value of the resolved location; anything unbacked reads zero.
    assign cur_val = mem_hit  ? mem.rdata
                   : ptr0_loc ? pointer_zero
                   : ptr1_loc ? pointer_one
                   : bank_loc ? {BANK_PAD, bank_select_bit} // [RULE16]
                   : ext_loc  ? ext_rdata
                   : ZERO_BYTE; // [RULE1] [RULE8]

    // A plain write beats a bit operation; set beats clear.
    assign upd      = wr_req | set_req | clr_req;
    assign next_val = wr_req ? wdata : bdm_bit_apply(cur_val, bit_sel, set_req); // [RULE3]

    // Protected registers never see a write strobe.
    assign next_ext_wr = upd && ext_loc && !prot_loc; // [RULE4]

    assign mem.we      = upd && mem_hit; // [RULE2]
    assign mem.bank    = tgt_bank;
    assign mem.idx     = tgt_low[6:0];
    assign mem.wdata   = next_val;
    assign mem.pwm_idx = pwm_idx;
    assign pwm_data    = mem.pwm_data; // [RULE15]

    // Pointers are ordinary registers, so inc and dec arrive as plain writes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pointer_zero <= PTR_RST;
        end else if (upd && ptr0_loc) begin
            pointer_zero <= next_val; // [RULE9]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pointer_one <= PTR_RST;
        end else if (upd && ptr1_loc) begin
            pointer_one <= next_val; // [RULE9]
        end
    end

    // The watchdog idle reset leaves the bank alone so a sleeping program
    // wakes in the bank it chose.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            if (!watchdog_timer_idle_rst) begin
                bank_select_bit <= BANK_RST; // [RULE11]
            end
        end else if (upd && bank_loc) begin
            bank_select_bit <= next_val[BANK_BIT]; // [RULE16]
        end
    end

    // The external write is registered, so it lands one clock after the
    // request; a read of that register in the next cycle sees the old value.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_wr    <= 1'b0;
            ext_waddr <= IDX_RST;
            ext_wdata <= ZERO_BYTE;
        end else begin
            ext_wr    <= next_ext_wr; // [RULE4]
            ext_waddr <= tgt_low[6:0];
            ext_wdata <= next_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata    <= ZERO_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rdata <= cur_val; // [RULE1] [RULE8]
            end
        end
    end

    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    unused_zero_a: assert property ( // [RULE1]
        rd_req && spec_hit && !own_loc && !ext_present |=> rdata == ZERO_BYTE
    ) else $error("unused special location did not read zero");

    gp_write_read_a: assert property ( // [RULE2]
        (wr_req && gp_hit && !rd_req)
        ##1 (rd_req && !upd && gp_hit && tgt_low == $past(tgt_low))
        |=> rdata == $past(wdata, 2)
    ) else $error("general purpose byte did not hold written value");

    bit_keep_a: assert property ( // [RULE3]
        (set_req || clr_req) && !wr_req && mem_hit
        |-> ((mem.wdata ^ mem.rdata) & ~bdm_bit_mask(bit_sel)) == ZERO_BYTE
    ) else $error("bit operation disturbed another bit");

    bit_value_a: assert property ( // [RULE3]
        set_req && !wr_req && mem_hit
        |-> (mem.wdata & bdm_bit_mask(bit_sel)) != ZERO_BYTE
    ) else $error("bit set left the bit clear");

    protect_a: assert property ( // [RULE4]
        upd && prot_loc |=> !ext_wr
    ) else $error("protected register received a write");

    ind_route_a: assert property ( // [RULE5]
        port0_hit && mem_hit |-> mem.idx == pointer_zero[6:0] && !mem.bank
    ) else $error("port zero did not follow its pointer");

    port0_bank_a: assert property ( // [RULE6]
        port0_hit && bank_select_bit |-> tgt_bank == BANK0
    ) else $error("port zero left bank 0");

    port1_bank_a: assert property ( // [RULE7]
        port1_hit && mem_hit
        |-> mem.bank == bank_select_bit && mem.idx == pointer_one[6:0]
    ) else $error("port one address not formed from bank and pointer");

    port_self_a: assert property ( // [RULE8]
        rd_req && port_loc |=> rdata == ZERO_BYTE
    ) else $error("indirect port location did not read zero");

    port_nowrite_a: assert property ( // [RULE8]
        upd && port_loc |-> !mem.we ##1 !ext_wr
    ) else $error("write to indirect port location took effect");

    pointer_load_a: assert property ( // [RULE9]
        wr_req && ptr1_loc |=> pointer_one == $past(wdata)
    ) else $error("pointer one did not load");

    bank_reset_a: assert property ( // [RULE11]
        @(posedge clk) disable iff (1'b0)
        !rst_n && !watchdog_timer_idle_rst |=> bank_select_bit == BANK_RST
    ) else $error("bank select not cleared by reset");

    bank_keep_a: assert property ( // [RULE11]
        @(posedge clk) disable iff (1'b0)
        !rst_n && watchdog_timer_idle_rst |=> $stable(bank_select_bit)
    ) else $error("bank select changed on watchdog idle reset");

    direct_bank_a: assert property ( // [RULE12]
        !indirect && (rd_req || upd) |-> !mem.bank
    ) else $error("direct access left bank 0");

    spec_noram_a: assert property ( // [RULE14]
        upd && !tgt_low[GP_BIT] |-> !mem.we
    ) else $error("special area write reached RAM");

    pwm_buffer_a: assert property ( // [RULE15]
        (wr_req && mem_hit && tgt_bank && tgt_low[6:0] == pwm_idx)
        ##1 (!upd && pwm_idx == $past(pwm_idx))
        |=> pwm_data == $past(wdata, 2)
    ) else $error("PWM buffer byte not seen by PWM port");

    bank_bits_a: assert property ( // [RULE16]
        rd_req && bank_loc |=> rdata[7:1] == BANK_PAD
        && rdata[BANK_BIT] == $past(bank_select_bit)
    ) else $error("bank select read back wrong");

    rd_pulse_a: assert property ( // [RULE2]
        rd_req |=> rd_valid
    ) else $error("read answer did not follow the request");

    rd_idle_a: assert property ( // [RULE2]
        !rd_req |=> !rd_valid
    ) else $error("read answer without a request");

    gp_read_a: assert property ( // [RULE2]
        rd_req && gp_hit |=> rdata == $past(mem.rdata)
    ) else $error("general purpose read returned wrong byte");

    ptr0_load_a: assert property ( // [RULE9]
        wr_req && ptr0_loc |=> pointer_zero == $past(wdata)
    ) else $error("pointer zero did not load");

    ptr_read_a: assert property ( // [RULE9]
        rd_req && ptr1_loc |=> rdata == $past(pointer_one)
    ) else $error("pointer one read back wrong");

    ext_write_a: assert property ( // [RULE4]
        wr_req && ext_loc && !prot_loc
        |=> ext_wr && ext_wdata == $past(wdata) && ext_waddr == $past(tgt_low[6:0])
    ) else $error("external register write not passed on");

    ext_quiet_a: assert property ( // [RULE4]
        !upd |=> !ext_wr
    ) else $error("external write strobe without a request");

    bank1_low_a: assert property ( // [RULE10]
        rd_req && tgt_bank && !tgt_low[GP_BIT] |=> rdata == ZERO_BYTE
    ) else $error("bank 1 special area did not read zero");

    ext_bank_a: assert property ( // [RULE12]
        tgt_bank |-> !ext_rd && !next_ext_wr
    ) else $error("bank 1 access reached an external register");

    cov_bank1_c: cover property (
        port1_hit && bank_select_bit && wr_req && mem_hit
    );

    cov_port0_c: cover property (
        port0_hit && bank_select_bit && rd_req && mem_hit
    );

    cov_bitop_c: cover property (
        clr_req && gp_hit ##1 rd_req && gp_hit
    );

    cov_ext_c: cover property (
        wr_req && ext_loc && !prot_loc ##1 ext_wr
    );

    cov_keep_c: cover property (
        @(posedge clk) disable iff (1'b0)
        bank_select_bit && !rst_n && watchdog_timer_idle_rst
    );

endmodule : bdm_top

// >>> test/bdm_ext_model.sv
// Behavioural model of the external special registers beside the data memory.
// Assumes the access logic presents ext_addr combinationally and strobes ext_wr.
`timescale 1ns/1ps
module bdm_ext_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] ext_addr,
    input  wire logic       ext_rd,
    output logic            ext_present,
    output logic      [7:0] ext_rdata,
    input  wire logic       ext_wr,
    input  wire logic [6:0] ext_waddr,
    input  wire logic [7:0] ext_wdata
);
    logic [7:0] regs [0:15];
    logic       in_map;

    // Location 0BH is left out of the map so that it reads as unused.
    assign in_map      = (ext_addr >= 7'h05) && (ext_addr <= 7'h0f);
    assign ext_present = in_map && (ext_addr != 7'h0b);
    // An absent register never echoes a stored value, so a bad decode cannot hide.
    assign ext_rdata   = ext_present ? regs[ext_addr[3:0]] : {1'b1, ~ext_addr};

    always @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 8'h30 + 8'(i);
            end
        // Every write to 00H-0FH is kept, so only the access logic can protect a register.
        end else if (ext_wr && (ext_waddr[6:4] == 3'h0)) begin
            regs[ext_waddr[3:0]] <= ext_wdata;
        end
    end
endmodule : bdm_ext_model

// >>> test/tb_top.sv
// Self-checking bench for the banked data memory access logic.
// Assumes the external model answers the special registers 05H-0FH except 0BH.
`timescale 1ns/1ps
module tb_top
    import bdm_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wd_rst = 1'b0;
    logic       rd_req = 1'b0;
    logic       wr_req = 1'b0;
    logic       set_req = 1'b0;
    logic       clr_req = 1'b0;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [6:0] pwm_idx = 7'h00;
    logic [7:0] rdata, ext_rdata, ext_wdata, pwm_data;
    logic [6:0] ext_addr, ext_waddr;
    logic       rd_valid, ext_rd, ext_present, ext_wr, bank_select_bit;
    int         n_mismatch = 0;
    int         num_checks = 0;

    always #25 clk = ~clk;

    bdm_top dut_u (.clk(clk), .rst_n(rst_n), .watchdog_timer_idle_rst(wd_rst), .addr(addr),
        .rd_req(rd_req), .wr_req(wr_req), .set_req(set_req), .clr_req(clr_req),
        .bit_sel(bit_sel), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid),
        .ext_addr(ext_addr), .ext_rd(ext_rd), .ext_present(ext_present),
        .ext_rdata(ext_rdata), .ext_wr(ext_wr), .ext_waddr(ext_waddr),
        .ext_wdata(ext_wdata), .pwm_idx(pwm_idx), .pwm_data(pwm_data),
        .bank_select_bit(bank_select_bit));

    bdm_ext_model ext_u (.clk(clk), .rst_n(rst_n), .ext_addr(ext_addr), .ext_rd(ext_rd),
        .ext_present(ext_present), .ext_rdata(ext_rdata), .ext_wr(ext_wr),
        .ext_waddr(ext_waddr), .ext_wdata(ext_wdata));

    task automatic complete_run;
        if ((n_mismatch == 0) && (num_checks > 0)) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk1

    // One request for one cycle; op is {read, write, set, clear}.
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic [3:0] op,
                       input logic [2:0] b);
        @(negedge clk);
        addr = a;
        wdata = d;
        bit_sel = b;
        {rd_req, wr_req, set_req, clr_req} = op;
        @(negedge clk);
        {rd_req, wr_req, set_req, clr_req} = 4'h0;
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 4'h4, 3'h0);
    endtask : wr

    // The answer lands exactly one edge after the read is taken.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        acc(a, 8'h00, 4'h8, 3'h0);
        chk1(rd_valid, 1'b1);
        chk8(rdata, exp);
    endtask : rd_chk

    task automatic do_reset(input logic wd);
        @(negedge clk);
        rst_n = 1'b0;
        wd_rst = wd;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        wd_rst = 1'b0;
    endtask : do_reset

    task automatic sc_ram;
        wr(8'h80, 8'ha5);
        wr(8'hff, 8'h3c);
        rd_chk(8'h80, 8'ha5);
        rd_chk(8'hff, 8'h3c);
        wr(8'h90, 8'hf0);
        acc(8'h90, 8'h00, 4'h2, 3'h0);
        acc(8'h90, 8'h00, 4'h1, 3'h7);
        rd_chk(8'h90, 8'h71);
    endtask : sc_ram

    // Every registered output but bank_select_bit as reset leaves it, looked at before any request.
    task automatic chk_reset_outs;
        chk8(rdata, 8'h00);
        chk1(rd_valid, 1'b0);
        chk1(ext_wr, 1'b0);
        chk8({1'b0, ext_waddr}, 8'h00);
        chk8(ext_wdata, 8'h00);
        chk8(pwm_data, 8'h00);
    endtask : chk_reset_outs

    // Requests on consecutive edges; priority of write over set over clear.
    task automatic sc_b2b;
        @(negedge clk);
        addr = 8'ha0;
        wdata = 8'h6b;
        wr_req = 1'b1;
        @(negedge clk);
        wr_req = 1'b0;
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        chk1(rd_valid, 1'b1);
        chk8(rdata, 8'h6b);
        acc(8'ha0, 8'h0f, 4'h6, 3'h7);
        acc(8'ha0, 8'h00, 4'h3, 3'h6);
        rd_chk(8'ha0, 8'h4f);
    endtask : sc_b2b

    // External register: read strobe at once, write strobe one clock late.
    task automatic sc_ext;
        @(negedge clk);
        addr = 8'h0d;
        wdata = 8'hc3;
        {rd_req, wr_req} = 2'b11;
        @(negedge clk);
        chk1(ext_rd, 1'b1);
        chk8({1'b0, ext_addr}, 8'h0d);
        chk8(rdata, 8'h3d);
        chk1(ext_wr, 1'b1);
        chk8({1'b0, ext_waddr}, 8'h0d);
        chk8(ext_wdata, 8'hc3);
        {rd_req, wr_req} = 2'b00;
        @(negedge clk);
        chk1(ext_wr, 1'b0);
        rd_chk(8'h0d, 8'hc3);
        acc(8'h0d, 8'h00, 4'h2, 3'h2);
        rd_chk(8'h0d, 8'hc7);
    endtask : sc_ext

    task automatic sc_special;
        rd_chk(8'h0b, 8'h00);
        wr(8'h0b, 8'h77);
        rd_chk(8'h0b, 8'h00);
        rd_chk(8'h7f, 8'h00);
        wr(PROT_ADDR, 8'hff);
        rd_chk(PROT_ADDR, 8'h38);
        wr(8'h0c, 8'h9a);
        rd_chk(8'h0c, 8'h9a);
    endtask : sc_special

    task automatic sc_indirect;
        wr(PTR0_ADDR, 8'h81);
        acc(PTR0_ADDR, 8'h00, 4'h2, 3'h1);
        rd_chk(PTR0_ADDR, 8'h83);
        wr(PORT0_ADDR, 8'h5e);
        rd_chk(8'h83, 8'h5e);
        wr(PTR0_ADDR, 8'h00);
        wr(PORT0_ADDR, 8'h11);
        rd_chk(PORT0_ADDR, 8'h00);
        rd_chk(PORT1_ADDR, 8'h00);
    endtask : sc_indirect

    task automatic sc_bank;
        wr(BANK_ADDR, 8'hff);
        rd_chk(BANK_ADDR, 8'h01);
        wr(8'h80, 8'h12);
        wr(PTR1_ADDR, 8'h80);
        wr(PORT1_ADDR, 8'h77);
        rd_chk(PORT1_ADDR, 8'h77);
        rd_chk(8'h80, 8'h12);
        wr(PTR0_ADDR, 8'h80);
        rd_chk(PORT0_ADDR, 8'h12);
        @(negedge clk);
        chk8(pwm_data, 8'h77);
        wr(PTR1_ADDR, 8'h10);
        rd_chk(PORT1_ADDR, 8'h00);
        acc(BANK_ADDR, 8'h00, 4'h1, 3'h0);
        wr(PTR1_ADDR, 8'h80);
        rd_chk(PORT1_ADDR, 8'h12);
        acc(BANK_ADDR, 8'h00, 4'h2, 3'h0);
        chk1(bank_select_bit, 1'b1);
        do_reset(1'b1);
        chk1(bank_select_bit, 1'b1);
        chk_reset_outs();
        do_reset(1'b0);
        chk1(bank_select_bit, 1'b0);
        rd_chk(PTR1_ADDR, 8'h00);
    endtask : sc_bank

    initial begin
        do_reset(1'b0);
        chk_reset_outs();
        sc_ram();
        sc_b2b();
        sc_special();
        sc_ext();
        sc_indirect();
        sc_bank();
        complete_run();
    end

    // A hang counts as a mismatch and still ends in the verdict.
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule : tb_top
